// ==== src/dctim_pkg.sv ====
// Purpose: constants and carrier types for the dual channel torque inhibit monitor
// Assumes: 50 MHz clock, synchronous active-low reset standing in for power-on
// Notes: times are kept in their printed units, cycle counts derived below
// Notes on behaviour
// - low pulses on either channel shorter than 2ms never assert the inhibit
// - a channel counts as low only after staying low about 6ms; the filter here counts it low after 4ms
// - both filtered channels low: drive tripped, start blocked, status output on
// - both high with brief test pulses: drive stays runnable, no inhibit
// - trip message raised at once on start or run if inhibit or fault
// - unconnected inputs read as low and trip at the first start attempt
// - history entry when inhibit active at start or arrives while running
// - no history entry when inhibit arrives while the drive is stopped
// - channels disagreeing over 3.0s latch a fault, tripped, status off
// - disagreement under 1.6s gives no latched fault, still tripped, status off
// - latched fault clears only at power-up reset, never by inputs
// - both high and no fault: drive enabled to run, status output off
package dctim_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned IGNORE_US       = 2000;
    localparam int unsigned REACT_US        = 6000;
    // threshold placed between the ignored width and the typical reaction
    localparam int unsigned FILTER_US       = 4000;
    localparam int unsigned FAULT_MIN_MS    = 1600;
    localparam int unsigned FAULT_MAX_MS    = 3000;
    localparam int unsigned FAULT_MS        = 2300;
    localparam int unsigned FILTER_CYC      = (FILTER_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FAULT_CYC       = (FAULT_MS * (CLK_HZ / 1000));
    localparam int unsigned IGNORE_CYC      = (IGNORE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned REACT_CYC       = (REACT_US * (CLK_HZ / 1_000_000));

    typedef enum logic [1:0] {
        DCTIM_STOPPED = 2'b00,
        DCTIM_RUNNING = 2'b01,
        DCTIM_TRIPPED = 2'b10
    } dctim_drive_e;

    // operator-facing indications
    typedef struct packed {
        logic trip_message;
        logic history_write;
        logic fault_latched;
    } dctim_report_s;
endpackage : dctim_pkg

// ==== src/dctim_chan_filter.sv ====
// Purpose: one channel synchroniser and low-time filter
// Assumes: raw input may be asynchronous to clk
// Notes: output resets low so an unconnected input starts in the inhibit state
`timescale 1ns/1ns
module dctim_chan_filter #(
    parameter int unsigned THRESH = dctim_pkg::FILTER_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // channel
    input  wire logic raw_in,
    output logic      filt_high
);
    import dctim_pkg::*;

    localparam int W = $clog2(THRESH + 1);
    localparam logic [W-1:0] THR = W'(THRESH);

    logic         sync1_ff;
    logic         sync2_ff;
    logic [W-1:0] low_cnt_ff;
    logic         filt_ff;

    wire          low_done = (low_cnt_ff == THR);
    wire  [W-1:0] nxt_low_cnt = sync2_ff ? '0 : (low_done ? low_cnt_ff : low_cnt_ff + W'(1));
    // rises on a high sample, falls only once the low has lasted the threshold
    wire          nxt_filt = sync2_ff ? 1'b1 : (low_done ? 1'b0 : filt_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff   <= 1'b0;
            sync2_ff   <= 1'b0;
            low_cnt_ff <= '0;
            filt_ff    <= 1'b0;
        end else begin
            sync1_ff   <= raw_in;
            sync2_ff   <= sync1_ff;
            low_cnt_ff <= nxt_low_cnt;
            filt_ff    <= nxt_filt;
        end
    end

    assign filt_high = filt_ff;
endmodule : dctim_chan_filter

// ==== src/dctim_top.sv ====
// Purpose: dual channel torque inhibit monitor for a motor drive
// Assumes: start_req and stop_req are one-cycle requests from run control
// Notes: status output is information only, not a safety guarantee
`timescale 1ns/1ns
module dctim_top #(
    parameter int unsigned FILTER_CYCLES = dctim_pkg::FILTER_CYC,
    parameter int unsigned FAULT_CYCLES  = dctim_pkg::FAULT_CYC
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // channel inputs
    input  wire logic               channel_a_input,
    input  wire logic               channel_b_input,
    // run control
    input  wire logic               start_req,
    input  wire logic               stop_req,
    input  wire logic               trip_ack,
    output logic                    drive_run,
    output logic                    torque_inhibit,
    // indications
    output logic                    inhibit_status_output,
    output dctim_pkg::dctim_report_s report
);
    import dctim_pkg::*;

    localparam int FW = $clog2(FAULT_CYCLES + 1);
    localparam logic [FW-1:0] FAULT_THR = FW'(FAULT_CYCLES);

    logic         a_high;
    logic         b_high;
    logic [FW-1:0] dis_cnt_ff;
    logic         fault_ff;
    dctim_drive_e state_ff;
    logic         run_ff;
    logic         inh_ff;
    logic         status_ff;
    logic         msg_ff;
    logic         hist_ff;

    // bit 0 is channel a, bit 1 is channel b
    wire  [1:0] chan_raw = {channel_b_input, channel_a_input};
    logic [1:0] chan_high;

    // each channel keeps its own filter so one stuck input cannot mask the other
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            dctim_chan_filter #(.THRESH(FILTER_CYCLES)) u_chan (
                .clk       (clk),
                .rst_n     (rst_n),
                .raw_in    (chan_raw[gi]),
                .filt_high (chan_high[gi])
            );
        end
    endgenerate

    assign a_high = chan_high[0];
    assign b_high = chan_high[1];

    // channel agreement decode
    wire both_low   = !a_high && !b_high;
    wire both_high  = a_high && b_high;
    wire disagree   = a_high ^ b_high;
    wire dis_done   = (dis_cnt_ff == FAULT_THR);
    // any inhibit cause: a low channel or the latched fault
    wire inhibit    = !both_high || fault_ff;
    wire start_hit  = start_req && (state_ff == DCTIM_STOPPED);
    wire inh_rise   = inhibit && (state_ff == DCTIM_RUNNING);

    // disagreement timer restarts whenever the channels agree again
    wire [FW-1:0] nxt_dis_cnt = !disagree ? '0 : (dis_done ? dis_cnt_ff : dis_cnt_ff + FW'(1));
    // fault is sticky until reset; only power-up clears it
    wire nxt_fault = fault_ff || (disagree && dis_done);

    dctim_drive_e nxt_state;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DCTIM_STOPPED: begin
                if (start_hit)
                    nxt_state = inhibit ? DCTIM_TRIPPED : DCTIM_RUNNING;
            end
            DCTIM_RUNNING: begin
                if (inhibit)
                    nxt_state = DCTIM_TRIPPED;
                else if (stop_req)
                    nxt_state = DCTIM_STOPPED;
            end
            DCTIM_TRIPPED: begin
                if (trip_ack)
                    nxt_state = DCTIM_STOPPED;
            end
            default: nxt_state = DCTIM_STOPPED;
        endcase
    end

    // history entry only for start-with-inhibit or inhibit while running
    wire nxt_hist   = (start_hit && inhibit) || inh_rise;
    wire nxt_msg    = (nxt_state == DCTIM_TRIPPED);
    // run needs healthy channels; brief test pulses never reach here
    wire nxt_run    = (nxt_state == DCTIM_RUNNING) && both_high && !nxt_fault;
    wire nxt_inh    = inhibit || nxt_fault;
    // status on only for the genuine both-low safe state without fault
    wire nxt_status = both_low && !nxt_fault;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dis_cnt_ff <= '0;
            fault_ff   <= 1'b0;
            state_ff   <= DCTIM_STOPPED;
            run_ff     <= 1'b0;
            inh_ff     <= 1'b1;
            status_ff  <= 1'b0;
            msg_ff     <= 1'b0;
            hist_ff    <= 1'b0;
        end else begin
            dis_cnt_ff <= nxt_dis_cnt;
            fault_ff   <= nxt_fault;
            state_ff   <= nxt_state;
            run_ff     <= nxt_run;
            inh_ff     <= nxt_inh;
            status_ff  <= nxt_status;
            msg_ff     <= nxt_msg;
            hist_ff    <= nxt_hist;
        end
    end

    assign drive_run             = run_ff;
    assign torque_inhibit        = inh_ff;
    assign inhibit_status_output = status_ff;
    assign report.trip_message   = msg_ff;
    assign report.history_write  = hist_ff;
    assign report.fault_latched  = fault_ff;
endmodule : dctim_top

// ==== sim/dctim_properties.sv ====
// Purpose: port-level timing checks for the torque inhibit monitor
// Assumes: idle is read as no run and no trip message
// Notes: none of these checks relaxes while a fault is latched
`timescale 1ns/1ns
module dctim_properties #(
    parameter int unsigned FILTER_CYCLES = 20,
    parameter int unsigned FAULT_CYCLES  = 100
) (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst_n,
    // inputs and outputs of the monitor
    input wire logic                    channel_a_input,
    input wire logic                    channel_b_input,
    input wire logic                    start_req,
    input wire logic                    stop_req,
    input wire logic                    trip_ack,
    input wire logic                    drive_run,
    input wire logic                    torque_inhibit,
    input wire logic                    inhibit_status_output,
    input wire dctim_pkg::dctim_report_s report
);
    import dctim_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire idle = !drive_run && !report.trip_message;
    sequence run_holds;
        drive_run [*8];
    endsequence
    sequence trip_logged;
        report.trip_message && report.history_write ##1 !report.history_write;
    endsequence
    run_ignore_a: assert property (drive_run && $fell(channel_a_input) |-> run_holds)
        else $error("run dropped on a short low");
    trip_log_a: assert property (start_req && idle && torque_inhibit |=> trip_logged)
        else $error("start under inhibit not logged");
    start_run_a: assert property (start_req && idle && !torque_inhibit |=> drive_run)
        else $error("start refused with healthy inputs");
    inhib_norun_a: assert property (torque_inhibit |-> !drive_run)
        else $error("running under inhibit");
    status_safe_a: assert property (inhibit_status_output |-> ##[0:1] (torque_inhibit && !report.fault_latched))
        else $error("status on without safe state");
    fault_hold_a: assert property (report.fault_latched |=> report.fault_latched && !inhibit_status_output)
        else $error("fault released or status on");
    hist_cause_a: assert property (report.history_write |-> $past(drive_run) || $past(start_req))
        else $error("history written while stopped");
    ack_clear_a: assert property (report.trip_message && trip_ack |-> ##[1:2] !report.trip_message)
        else $error("trip message not cleared");
    stop_halt_a: assert property (drive_run && stop_req |=> !drive_run)
        else $error("run kept after stop");
endmodule : dctim_properties
bind dctim_top dctim_properties #(.FILTER_CYCLES(FILTER_CYCLES), .FAULT_CYCLES(FAULT_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .channel_a_input(channel_a_input), .channel_b_input(channel_b_input),
    .start_req(start_req), .stop_req(stop_req), .trip_ack(trip_ack), .drive_run(drive_run),
    .torque_inhibit(torque_inhibit), .inhibit_status_output(inhibit_status_output), .report(report));

// ==== sim/dctim_safety_ctl.sv ====
// Purpose: safety controller driving both channels with test pulses
// Assumes: pulse requests name one channel at a time
// Notes: pulse width of 10 cycles stays under the sim filter of 20
`timescale 1ns/1ns
module dctim_safety_ctl (
    // clock
    input wire logic       clk,
    // commands
    input wire logic [1:0] level,
    input wire logic [1:0] pulse,
    // channels
    output logic           channel_a_input,
    output logic           channel_b_input
);
    logic [3:0] cnt_ff = 4'h0;
    logic [1:0] sel_ff = 2'h0;
    always_ff @(posedge clk) begin
        if (pulse != 2'h0) begin
            sel_ff <= pulse;
            cnt_ff <= 4'hA;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    wire busy = (cnt_ff != 4'h0);
    assign channel_a_input = level[0] && !(busy && sel_ff[0]);
    assign channel_b_input = level[1] && !(busy && sel_ff[1]);
endmodule : dctim_safety_ctl

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the torque inhibit monitor
// Assumes: short filter and fault counts so the run stays brief
// Notes: history pulses are counted on every rising clock edge, not sampled
`timescale 1ns/1ns
module tb;
    import dctim_pkg::*;
    localparam int unsigned FILT = 20;
    localparam int unsigned FLT  = 100;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          start_req = 1'b0;
    logic          stop_req = 1'b0;
    logic          trip_ack = 1'b0;
    logic [1:0]    level = 2'h0;
    logic [1:0]    pulse = 2'h0;
    logic          cha, chb, drv, inh, sts;
    dctim_report_s rep;
    int            fail_count = 0;
    int            n_tests = 0;
    int            hist_n = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (rep.history_write === 1'b1) hist_n++;
    dctim_safety_ctl i_ctl (.clk(clk), .level(level), .pulse(pulse), .channel_a_input(cha), .channel_b_input(chb));
    dctim_top #(.FILTER_CYCLES(FILT), .FAULT_CYCLES(FLT)) i_dut (.clk(clk), .rst_n(rst_n), .channel_a_input(cha),
        .channel_b_input(chb), .start_req(start_req), .stop_req(stop_req), .trip_ack(trip_ack), .drive_run(drv),
        .torque_inhibit(inh), .inhibit_status_output(sts), .report(rep));
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task check(input string what, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    // one-cycle request: {start, ack, pulse b, pulse a}
    task go(input logic [3:0] w);
        {start_req, trip_ack, pulse} = w;
        cyc(1);
        {start_req, trip_ack, pulse} = 4'h0;
    endtask : go
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task t_open;
        go(4'h8);
        cyc(2);
        check("trip_msg", rep.trip_message, 1'b1);
        check("hist", hist_n == 1, 1'b1);
        cyc(FILT + 5);
        check("status", sts, 1'b1);
        check("run", drv, 1'b0);
        go(4'h4);
        cyc(1);
        check("msg_clr", rep.trip_message, 1'b0);
        $display("open inputs done");
    endtask : t_open
    task t_stopped;
        level = 2'h3;
        cyc(FILT + 10);
        check("status", sts, 1'b0);
        check("inhibit", inh, 1'b0);
        level = 2'h0;
        cyc(FILT + 10);
        check("hist", hist_n == 1, 1'b1);
        check("inhibit", inh, 1'b1);
        $display("stopped inhibit done");
    endtask : t_stopped
    task t_run;
        level = 2'h3;
        cyc(FILT + 10);
        go(4'h8);
        cyc(1);
        check("run", drv, 1'b1);
        go(4'h1);
        cyc(15);
        go(4'h2);
        cyc(15);
        check("run", drv, 1'b1);
        check("inhibit", inh, 1'b0);
        stop_req = 1'b1;
        cyc(1);
        stop_req = 1'b0;
        cyc(1);
        check("stop", drv, 1'b0);
        check("hist", hist_n == 1, 1'b1);
        go(4'h8);
        cyc(1);
        check("restart", drv, 1'b1);
        $display("test pulses done");
    endtask : t_run
    task t_trip;
        int i;
        level = 2'h2;
        cyc(15);
        check("run_early", drv, 1'b1);
        for (i = 0; i < 60 && rep.trip_message !== 1'b1; i++) cyc(1);
        if (i == 60) begin
            fail_count++;
            complete_run;
        end
        check("run", drv, 1'b0);
        cyc(2);
        check("hist", hist_n == 2, 1'b1);
        check("status", sts, 1'b0);
        cyc(20);
        check("fault", rep.fault_latched, 1'b0);
        level = 2'h0;
        go(4'h4);
        $display("trip while running done");
    endtask : t_trip
    task t_fault;
        level = 2'h1;
        cyc(FLT + 40);
        check("fault", rep.fault_latched, 1'b1);
        check("status", sts, 1'b0);
        level = 2'h3;
        cyc(FILT + 10);
        check("fault", rep.fault_latched, 1'b1);
        go(4'h8);
        cyc(1);
        check("run", drv, 1'b0);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        check("fault_rst", rep.fault_latched, 1'b0);
        $display("fault latch done");
    endtask : t_fault
    initial begin
        cyc(2);
        rst_n = 1'b1;
        t_open;
        t_stopped;
        t_run;
        t_trip;
        t_fault;
        complete_run;
    end
endmodule : tb
